// ### hdl/bsx_map.svh
`ifndef BSX_MAP_SVH
`define BSX_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define BSX_OFF_ACC 8'h00
`define BSX_OFF_STATUS 8'h04
`define BSX_OFF_INSTR 8'h08
`define BSX_OFF_FPTR 8'h0c
`define BSX_OFF_FDATA 8'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BSX_ST_CARRY 0
`define BSX_ST_DIGIT 1
`define BSX_ST_ZERO 2
`define BSX_IN_OP_MSB 1
`define BSX_IN_OP_LSB 0
`define BSX_IN_DEST 4
`define BSX_IN_FADDR_MSB 14
`define BSX_IN_FADDR_LSB 8
`define BSX_IN_LIT_MSB 23
`define BSX_IN_LIT_LSB 16

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define BSX_RST_ACC 8'h00
`define BSX_RST_FLAGS 3'h0
`define BSX_RST_FPTR 7'h00

`endif

// ### hdl/bsx_pkg.sv
package bsx_pkg;

   typedef enum logic [1:0]
   {
      BSX_OP_SUB = 2'h0,
      BSX_OP_XORL = 2'h1,
      BSX_OP_XORW = 2'h2,
      BSX_OP_SWAP = 2'h3
   } bsx_op_e;

   typedef struct packed
   {
      logic [7:0] literal_byte;
      logic [6:0] faddr;
      logic result_target_bit;
      bsx_op_e op;
   } bsx_inst_s;

   typedef struct packed
   {
      logic null_result_flag;
      logic digit_borrow_flag;
      logic borrow_inverse_flag;
   } bsx_flags_s;

endpackage

// ### hdl/bsx_alu.sv
`timescale 1ns/1ps
`default_nettype none

module bsx_alu
   import bsx_pkg::*;
(
   input wire bsx_op_e op,
   input wire logic [7:0] acc,
   input wire logic [7:0] fval,
   input wire logic [7:0] literal_byte,
   input wire bsx_flags_s flags_in,
   output logic [7:0] result,
   output bsx_flags_s flags_out
);

   logic [7:0] diff_w;
   logic [7:0] xorl_w;
   logic [7:0] xorw_w;
   logic [7:0] swap_w;

   assign diff_w = fval - acc;
   assign xorl_w = acc ^ literal_byte;
   assign xorw_w = acc ^ fval;
   assign swap_w = {fval[3:0], fval[7:4]};

   // Each zero test reads its own operation's value, so the result never feeds back into itself.
   always_comb
   begin
      result = diff_w;
      flags_out = flags_in;
      case (op)
         BSX_OP_SUB:
         begin
            result = diff_w;
            flags_out.borrow_inverse_flag = (acc <= fval);
            flags_out.digit_borrow_flag = (acc[3:0] <= fval[3:0]);
            flags_out.null_result_flag = (diff_w == 8'h00);
         end
         BSX_OP_XORL:
         begin
            result = xorl_w;
            flags_out.null_result_flag = (xorl_w == 8'h00);
         end
         BSX_OP_XORW:
         begin
            result = xorw_w;
            flags_out.null_result_flag = (xorw_w == 8'h00);
         end
         BSX_OP_SWAP:
         begin
            result = swap_w;
         end
         default:
         begin
            result = diff_w;
         end
      endcase
   end

endmodule // bsx_alu

`default_nettype wire

// ### hdl/bsx_regfile.sv
`timescale 1ns/1ps
`default_nettype none

module bsx_regfile
   import bsx_pkg::*;
(
   input wire logic mclk,
   input wire logic [6:0] raddr,
   output logic [7:0] rdata,
   input wire logic we,
   input wire logic [6:0] waddr,
   input wire logic [7:0] wdata
);

   // The read is combinational so an instruction fetches and writes back in one cycle.
   logic [7:0] mem [0:127];

   assign rdata = mem[raddr];

   always_ff @(posedge mclk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
   end

endmodule // bsx_regfile

`default_nettype wire

// ### hdl/bsx_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "bsx_map.svh"

module bsx_top
   import bsx_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   logic [7:0] acc_r;
   bsx_flags_s flags_r;
   bsx_inst_s inst_r;
   logic [6:0] fptr_r;
   logic [31:0] prdata_r;
   logic pslverr_r;

   // ----------------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------------
   logic setup_w;
   logic access_w;
   logic sel_acc;
   logic sel_stat;
   logic sel_inst;
   logic sel_fptr;
   logic sel_fdat;
   logic sel_none;
   logic wr_acc;
   logic wr_stat;
   logic wr_fptr;
   logic wr_fdat;
   logic exec_w;
   logic [31:0] rd_mux;
   logic [31:0] inst_word;

   assign setup_w = psel && !penable;
   assign access_w = psel && penable;
   assign sel_acc = (paddr == `BSX_OFF_ACC);
   assign sel_stat = (paddr == `BSX_OFF_STATUS);
   assign sel_inst = (paddr == `BSX_OFF_INSTR);
   assign sel_fptr = (paddr == `BSX_OFF_FPTR);
   assign sel_fdat = (paddr == `BSX_OFF_FDATA);
   assign sel_none = !(sel_acc || sel_stat || sel_inst || sel_fptr || sel_fdat);
   assign wr_acc = access_w && pwrite && sel_acc;
   assign wr_stat = access_w && pwrite && sel_stat;
   assign wr_fptr = access_w && pwrite && sel_fptr;
   assign wr_fdat = access_w && pwrite && sel_fdat;
   // Writing the instruction word executes it at the end of the access phase.
   assign exec_w = access_w && pwrite && sel_inst;

   // Zero wait states: every transfer, instructions included, ends in its first access cycle.
   assign pready = 1'b1;
   assign prdata = prdata_r;
   assign pslverr = pslverr_r;

   // ----------------------------------------------------------------------
   // Instruction decode
   // ----------------------------------------------------------------------
   bsx_inst_s inst_w;
   logic regform_w;
   logic to_file_w;

   assign inst_w.op = bsx_op_e'(pwdata[`BSX_IN_OP_MSB:`BSX_IN_OP_LSB]);
   assign inst_w.result_target_bit = pwdata[`BSX_IN_DEST];
   assign inst_w.faddr = pwdata[`BSX_IN_FADDR_MSB:`BSX_IN_FADDR_LSB];
   assign inst_w.literal_byte = pwdata[`BSX_IN_LIT_MSB:`BSX_IN_LIT_LSB];
   assign regform_w = (inst_w.op != BSX_OP_XORL);
   // The literal form has no register operand, so its target bit is ignored.
   assign to_file_w = regform_w && inst_w.result_target_bit;

   assign inst_word = {8'h00, inst_r.literal_byte, 1'b0, inst_r.faddr, 3'h0,
                       inst_r.result_target_bit, 2'h0, inst_r.op};

   // ----------------------------------------------------------------------
   // Datapath
   // ----------------------------------------------------------------------
   logic [6:0] rf_raddr;
   logic [7:0] rf_rdata;
   logic rf_we;
   logic [6:0] rf_waddr;
   logic [7:0] rf_wdata;
   logic [7:0] alu_res;
   bsx_flags_s alu_flags;

   assign rf_raddr = exec_w ? inst_w.faddr : fptr_r;
   assign rf_we = (exec_w && to_file_w) || wr_fdat;
   assign rf_waddr = exec_w ? inst_w.faddr : fptr_r;
   assign rf_wdata = exec_w ? alu_res : pwdata[7:0];

   bsx_regfile u_regfile
   (
      .mclk(mclk),
      .raddr(rf_raddr),
      .rdata(rf_rdata),
      .we(rf_we),
      .waddr(rf_waddr),
      .wdata(rf_wdata)
   );

   bsx_alu u_alu
   (
      .op(inst_w.op),
      .acc(acc_r),
      .fval(rf_rdata),
      .literal_byte(inst_w.literal_byte),
      .flags_in(flags_r),
      .result(alu_res),
      .flags_out(alu_flags)
   );

   assign rd_mux = sel_acc ? {24'h000000, acc_r} :
                   sel_stat ? {29'h00000000, flags_r} :
                   sel_inst ? inst_word :
                   sel_fptr ? {25'h0000000, fptr_r} :
                   sel_fdat ? {24'h000000, rf_rdata} : 32'h00000000;

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         acc_r <= `BSX_RST_ACC;
      end
      else if (exec_w && !to_file_w)
      begin
         acc_r <= alu_res;
      end
      else if (wr_acc)
      begin
         acc_r <= pwdata[7:0];
      end
   end

   // An instruction and a status write never share a cycle, so no priority is lost here.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         flags_r <= `BSX_RST_FLAGS;
      end
      else if (exec_w)
      begin
         flags_r <= alu_flags;
      end
      else if (wr_stat)
      begin
         flags_r <= pwdata[2:0];
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         inst_r <= '0;
         fptr_r <= `BSX_RST_FPTR;
      end
      else
      begin
         if (exec_w)
         begin
            inst_r <= inst_w;
         end
         if (wr_fptr)
         begin
            fptr_r <= pwdata[6:0];
         end
      end
   end

   // Read data and error are captured in the setup cycle so both leave from flip-flops.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         prdata_r <= 32'h00000000;
         pslverr_r <= 1'b0;
      end
      else if (setup_w)
      begin
         prdata_r <= pwrite ? 32'h00000000 : rd_mux;
         pslverr_r <= sel_none;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   logic exec_sub;
   logic exec_xorl;
   logic exec_xorw;
   logic exec_swap;
   logic [7:0] chk_diff;
   logic chk_le;
   logic chk_dle;
   logic [7:0] chk_xorl;
   logic [7:0] chk_xorw;
   logic [7:0] chk_swap;

   assign exec_sub = exec_w && (inst_w.op == BSX_OP_SUB);
   assign exec_xorl = exec_w && (inst_w.op == BSX_OP_XORL);
   assign exec_xorw = exec_w && (inst_w.op == BSX_OP_XORW);
   assign exec_swap = exec_w && (inst_w.op == BSX_OP_SWAP);
   assign chk_diff = rf_rdata - acc_r;
   assign chk_le = (acc_r <= rf_rdata);
   assign chk_dle = (acc_r[3:0] <= rf_rdata[3:0]);
   assign chk_xorl = acc_r ^ inst_w.literal_byte;
   assign chk_xorw = acc_r ^ rf_rdata;
   assign chk_swap = {rf_rdata[3:0], rf_rdata[7:4]};

   a_sub_value: assert property (exec_sub && !inst_w.result_target_bit |=>
      acc_r == $past(chk_diff))
      else $error("subtract result wrong in accumulator");

   a_sub_borrow: assert property (exec_sub |=>
      flags_r.borrow_inverse_flag == $past(chk_le))
      else $error("borrow-inverse flag wrong after subtract");

   a_sub_digit: assert property (exec_sub |=>
      flags_r.digit_borrow_flag == $past(chk_dle))
      else $error("digit-borrow flag wrong after subtract");

   a_sub_zero: assert property (exec_sub |=>
      flags_r.null_result_flag == ($past(chk_diff) == 8'h00))
      else $error("zero flag wrong after subtract");

   a_file_target: assert property (exec_w && to_file_w |->
      rf_we && rf_waddr == inst_w.faddr ##1 acc_r == $past(acc_r))
      else $error("register-target result not written back to register");

   a_acc_target: assert property (exec_w && regform_w && !inst_w.result_target_bit |->
      !rf_we)
      else $error("accumulator-target result written to register");

   a_file_data: assert property (exec_w && to_file_w |-> rf_wdata ==
      (exec_sub ? chk_diff : (exec_xorw ? chk_xorw : chk_swap)))
      else $error("register-target result value wrong");

   a_xorl_only_zero: assert property (exec_xorl |=> acc_r == $past(chk_xorl) &&
      $stable(flags_r.borrow_inverse_flag) && $stable(flags_r.digit_borrow_flag))
      else $error("literal xor result or flags wrong");

   a_xorl_zero: assert property (exec_xorl |=>
      flags_r.null_result_flag == ($past(chk_xorl) == 8'h00))
      else $error("literal xor zero flag wrong");

   a_xorw_only_zero: assert property (exec_xorw |=>
      $stable(flags_r.borrow_inverse_flag) && $stable(flags_r.digit_borrow_flag) &&
      flags_r.null_result_flag == ($past(chk_xorw) == 8'h00))
      else $error("register xor flags wrong");

   a_xorw_value: assert property (exec_xorw && !inst_w.result_target_bit |=>
      acc_r == $past(chk_xorw))
      else $error("register xor result wrong in accumulator");

   a_swap_flags: assert property (exec_swap |=> $stable(flags_r))
      else $error("nibble exchange changed a flag");

   a_swap_value: assert property (exec_swap && !inst_w.result_target_bit |=>
      acc_r == $past(chk_swap))
      else $error("nibble exchange result wrong");

   a_zero_follows: assert property (exec_w && !exec_swap && !to_file_w |=>
      flags_r.null_result_flag == (acc_r == 8'h00))
      else $error("zero flag disagrees with accumulator result");

   a_acc_holds: assert property (!exec_w && !wr_acc |=> $stable(acc_r))
      else $error("accumulator changed without a cause");

   c_sub_borrow: cover property (exec_sub ##1 !flags_r.borrow_inverse_flag);
   c_xorl_zero: cover property (exec_xorl ##1 flags_r.null_result_flag);
   c_swap_file: cover property (exec_swap && inst_w.result_target_bit);
   c_unmapped: cover property (access_w && pslverr);
   c_sub_file: cover property (exec_sub && to_file_w);

endmodule // bsx_top

`default_nettype wire

// ### verification/bsx_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "bsx_map.svh"

module testbench
   import bsx_pkg::*;
();
   logic mclk;
   logic rst;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [31:0] rdv;
   logic errv;
   int err_count;
   int checked;

   bsx_top uut
   (
      .mclk(mclk),
      .rst(rst),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr)
   );

   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // ----------------------------------------------------------------
   // Bus access and comparison
   // ----------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      begin
         n = 0;
         @(posedge mclk);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge mclk);
         penable <= 1'b1;
         do
         begin
            @(posedge mclk);
            n++;
         end
         while (pready !== 1'b1 && n < 16);
         if (n >= 16)
         begin
            err_count++;
            $display("MISMATCH at %0t: no pready, got %h exp %h", $time, pready, 1'b1);
         end
         rdv = prdata;
         errv = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         checked++;
         if (got !== exp)
         begin
            err_count++;
            $display("MISMATCH at %0t: got %h exp %h", $time, got, exp);
         end
      end
   endtask

   task automatic finish_test();
      begin
         $display("checked %0d err_count %0d", checked, err_count);
         if (err_count == 0 && checked > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask

   // Loads operands, executes one instruction, then reads every place it may have touched.
   task automatic run(input bsx_op_e op, input logic d, input logic [6:0] a,
                      input logic [7:0] k, input logic [7:0] w, input logic [7:0] f,
                      input logic [2:0] st);
      logic [7:0] r;
      logic [2:0] es;
      logic [31:0] iw;
      logic to_f;
      begin
         iw = {8'h00, k, 1'b0, a, 3'h0, d, 2'h0, op};
         es = st;
         to_f = d && (op != BSX_OP_XORL);
         case (op)
            BSX_OP_SUB:
            begin
               r = f - w;
               es = {r == 8'h00, w[3:0] <= f[3:0], w <= f};
            end
            BSX_OP_XORL:
            begin
               r = w ^ k;
               es[2] = (r == 8'h00);
            end
            BSX_OP_XORW:
            begin
               r = w ^ f;
               es[2] = (r == 8'h00);
            end
            default: r = {f[3:0], f[7:4]};
         endcase
         apb(1'b1, `BSX_OFF_ACC, {24'h0, w});
         apb(1'b1, `BSX_OFF_STATUS, {29'h0, st});
         apb(1'b1, `BSX_OFF_FPTR, {25'h0, a});
         apb(1'b1, `BSX_OFF_FDATA, {24'h0, f});
         apb(1'b1, `BSX_OFF_INSTR, iw);
         apb(1'b0, `BSX_OFF_ACC, 32'h0);
         chk(rdv, {24'h0, to_f ? w : r});
         apb(1'b0, `BSX_OFF_FDATA, 32'h0);
         chk(rdv, {24'h0, to_f ? r : f});
         apb(1'b0, `BSX_OFF_STATUS, 32'h0);
         chk(rdv, {29'h0, es});
         apb(1'b0, `BSX_OFF_INSTR, 32'h0);
         chk(rdv, iw);
      end
   endtask

   initial
   begin
      #(25 * 5000);
      err_count++;
      finish_test();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      err_count = 0;
      checked = 0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      apb(1'b0, `BSX_OFF_ACC, 32'h0);
      chk(rdv, 32'h0);
      apb(1'b0, `BSX_OFF_STATUS, 32'h0);
      chk(rdv, 32'h0);
      apb(1'b0, `BSX_OFF_FPTR, 32'h0);
      chk(rdv, 32'h0);
      apb(1'b1, 8'h14, 32'hffffffff);
      chk({31'h0, errv}, 32'h1);
      apb(1'b0, 8'h14, 32'h0);
      chk({rdv[30:0], errv}, 32'h1);
      run(BSX_OP_SUB, 1'b0, 7'h05, 8'h00, 8'h05, 8'h05, 3'h0);
      run(BSX_OP_SUB, 1'b1, 7'h11, 8'h00, 8'h06, 8'h05, 3'h7);
      run(BSX_OP_SUB, 1'b0, 7'h22, 8'h00, 8'h18, 8'h21, 3'h4);
      run(BSX_OP_SUB, 1'b1, 7'h7f, 8'h00, 8'h00, 8'h00, 3'h0);
      run(BSX_OP_XORL, 1'b1, 7'h01, 8'ha5, 8'ha5, 8'h77, 3'h3);
      run(BSX_OP_XORL, 1'b0, 7'h02, 8'h0f, 8'hf0, 8'h00, 3'h4);
      run(BSX_OP_XORW, 1'b0, 7'h00, 8'h00, 8'h3c, 8'h3c, 3'h3);
      run(BSX_OP_XORW, 1'b1, 7'h7f, 8'h00, 8'h3c, 8'hc3, 3'h7);
      run(BSX_OP_SWAP, 1'b0, 7'h30, 8'h00, 8'h99, 8'ha5, 3'h5);
      run(BSX_OP_SWAP, 1'b1, 7'h40, 8'h00, 8'h00, 8'h12, 3'h2);
      apb(1'b1, `BSX_OFF_ACC, 32'hffffff5a);
      apb(1'b0, `BSX_OFF_ACC, 32'h0);
      chk(rdv, 32'h0000005a);
      finish_test();
   end
endmodule // testbench

`default_nettype wire
